// ---- design/fault_frame_regs.vh ----
// constants for the access-fault frame status block
`ifndef FAULT_FRAME_REGS_VH
`define FAULT_FRAME_REGS_VH
// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define OFS_STATUS 8'h00
`define OFS_MASK 8'h04
`define OFS_SPECIAL 8'h08
`define OFS_FADDR 8'h0C
`define OFS_SLOT1_STAT 8'h10
`define OFS_SLOT2_STAT 8'h14
`define OFS_SLOT3_STAT 8'h18
`define OFS_SLOT1_ADDR 8'h1C
`define OFS_SLOT1_DATA 8'h20
`define OFS_SLOT2_DATA 8'h24
`define OFS_SLOT3_DATA 8'h28
`define OFS_LINE0 8'h2C
`define OFS_LINE1 8'h30
`define OFS_LINE2 8'h34
`define OFS_LINE3 8'h38
`define OFS_CTRL 8'h3C
// ***************************************************************
// field positions
// ***************************************************************
`define SLOT_VALID 7
`define SLOT_TYPE_HI 6
`define SLOT_TYPE_LO 5
`define SPECIAL_RW 8
`define SPECIAL_PUSH 9
`define SPECIAL_TRACE 10
`define CTRL_RET 0
`define CTRL_STORED 1
// ***************************************************************
// encodings
// ***************************************************************
`define TYPE_NORMAL 2'h0
`define TYPE_BLOCK 2'h1
`define MOD_PUSH 3'h0
`define KIND_READ 3'h0
`define KIND_WRITE 3'h1
`define KIND_BLOCK 3'h2
`define KIND_PRIV 3'h3
`define KIND_PUSH 3'h4
`define SIZE_SLOT3_CAP 2'h2
`define SIZE_LINE 2'h3
`define RET_LAST 4'hD
`define RST_ZERO 32'h0000_0000
`endif

// ---- design/fault_classify.v ----
// fault classification into write-back status fields
`timescale 1ns/10ps
`include "fault_frame_regs.vh"
module fault_classify (
    input wire [2:0] kind_i,
    input wire rw_i,
    input wire [1:0] type_i,
    input wire [2:0] mod_i,
    input wire wb2_pend_i,
    input wire [1:0] wb2_type_i,
    input wire [1:0] wb2_size_i,
    input wire wb3_pend_i,
    input wire [1:0] wb3_size_i,
    output reg v1_o,
    output reg v2_o,
    output reg v3_o,
    output reg [1:0] type1_o,
    output reg [1:0] type3_o,
    output reg [1:0] size3_o,
    output reg push_o,
    output reg rw_o
);
    // push flag follows the recorded type and modifier only, never the kind code
    always @* begin
        // push exactly type 0, modifier 0
        push_o = (type_i == `TYPE_NORMAL) && (mod_i == `MOD_PUSH);
        rw_o = rw_i;
        v1_o = 1'b0;
        v2_o = wb2_pend_i;
        v3_o = wb3_pend_i;
        type1_o = type_i;
        type3_o = `TYPE_NORMAL;
        size3_o = wb3_size_i;
        case (kind_i)
            `KIND_READ: begin
                v2_o = 1'b0;
            end
            `KIND_WRITE: begin
                rw_o = 1'b0;
                v1_o = 1'b1;
            end
            `KIND_BLOCK: begin
                rw_o = 1'b0;
                v1_o = 1'b1;
                type1_o = `TYPE_BLOCK;
            end
            `KIND_PRIV: begin
                rw_o = 1'b0;
                v2_o = 1'b1;
            end
            `KIND_PUSH: begin
                rw_o = 1'b0;
                type1_o = `TYPE_NORMAL;
            end
            default: begin
                v2_o = 1'b0;
                v3_o = 1'b0;
            end
        endcase
        if (push_o) begin
            v1_o = 1'b0;
        end
        if (v2_o && (wb2_type_i == `TYPE_BLOCK)) begin
            v3_o = 1'b0;
        end
        if (size3_o == `SIZE_LINE) begin
            size3_o = `SIZE_SLOT3_CAP;
        end
    end
endmodule // fault_classify

// ---- design/access_fault_frame_status.v ----
// access-fault frame capture with wishbone register view
`timescale 1ns/10ps
`include "fault_frame_regs.vh"
// Behaviour
// - long-word push fault codes failing word in address bits 3..2
// - normal write error: write, fault address, valid slot one equal address
// - block-move write error: type 1, slot one valid, four words saved
// - privilege fault: instruction address, slot two valid, only slot three extra
// - slot three never block move, size never line
// - push flag exactly when type 00 and modifier 000
// - each status field has valid bit, block move is type 01
// - return reads only frame offsets 0 through 0xD
// - pending trace at return starts trace processing two cycles after the return write
// - read fault never has slot one or two valid
// - push faults leave slot one valid clear
// - block move in slot two never with valid slot three
// - long-word push still holds all four line words
// - block move pending in slot two implies its read hit cache
// - push and write faults report up to two further writes
// - push error: write, type 0, modifier 0, four words saved
module access_fault_frame_status (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire fault_i,
    input wire [2:0] fault_kind_i,
    input wire fault_rw_i,
    input wire [1:0] fault_type_i,
    input wire [2:0] fault_mod_i,
    input wire [1:0] fault_size_i,
    input wire [31:0] fault_addr_i,
    input wire [31:0] instr_addr_i,
    input wire [1:0] failed_word_i,
    input wire wb1_data_i_valid,
    input wire [31:0] wb1_data_i,
    input wire wb2_pend_i,
    input wire [1:0] wb2_type_i,
    input wire [1:0] wb2_size_i,
    input wire wb2_hit_i,
    input wire [31:0] wb2_data_i,
    input wire wb3_pend_i,
    input wire [1:0] wb3_size_i,
    input wire [31:0] wb3_data_i,
    input wire [127:0] line_i,
    input wire trace_pend_i,
    input wire frame_stored_i,
    input wire [3:0] ret_offset_i,
    input wire ret_rd_i,
    output reg ret_ok_o,
    output reg trace_start_o,
    output reg hit_error_o,
    output wire irq_o
);
    // ***************************************************************
    // frame fields
    // ***************************************************************
    reg [15:0] special_status_word_ff;
    reg [31:0] fault_address_ff;
    reg [7:0] writeback_one_status_ff;
    reg [7:0] writeback_two_status_ff;
    reg [7:0] writeback_three_status_ff;
    reg [31:0] writeback_one_address_ff;
    reg [31:0] writeback_one_data_ff;
    reg [31:0] writeback_two_data_ff;
    reg [31:0] writeback_three_data_ff;
    reg [31:0] lw_ff [0:3];
    reg held_ff;
    reg [2:0] status_ff;
    reg [2:0] mask_ff;
    reg ack_ff;
    reg in_ret_ff;
    wire v1, v2, v3, push, rw;
    wire [1:0] type1, type3, size3;
    integer i;

    // push records type and modifier zero
    wire is_push_kind = (fault_kind_i == `KIND_PUSH);
    wire [1:0] rec_type = is_push_kind ? `TYPE_NORMAL : fault_type_i;
    wire [2:0] rec_mod = is_push_kind ? `MOD_PUSH : fault_mod_i;

    fault_classify fault_classify_i (
        .kind_i(fault_kind_i),
        .rw_i(fault_rw_i),
        .type_i(rec_type),
        .mod_i(rec_mod),
        .wb2_pend_i(wb2_pend_i),
        .wb2_type_i(wb2_type_i),
        .wb2_size_i(wb2_size_i),
        .wb3_pend_i(wb3_pend_i),
        .wb3_size_i(wb3_size_i),
        .v1_o(v1),
        .v2_o(v2),
        .v3_o(v3),
        .type1_o(type1),
        .type3_o(type3),
        .size3_o(size3),
        .push_o(push),
        .rw_o(rw)
    );

    // status byte: valid, type, size
    function [7:0] wbs;
        input v;
        input [1:0] tt;
        input [1:0] sz;
        begin
            wbs = {v, tt, 3'h0, sz};
        end
    endfunction

    wire take = fault_i && !held_ff;
    wire saves_line = (fault_kind_i == `KIND_BLOCK) || push;
    wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
    wire wb_wr = wb_req && wb_we_i;

    // ***************************************************************
    // capture
    // ***************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            held_ff <= 1'b0;
            special_status_word_ff <= 16'h0000;
            fault_address_ff <= `RST_ZERO;
            writeback_one_status_ff <= 8'h00;
            writeback_two_status_ff <= 8'h00;
            writeback_three_status_ff <= 8'h00;
            writeback_one_address_ff <= `RST_ZERO;
            writeback_one_data_ff <= `RST_ZERO;
            writeback_two_data_ff <= `RST_ZERO;
            writeback_three_data_ff <= `RST_ZERO;
            for (i = 0; i < 4; i = i + 1) begin
                lw_ff[i] <= `RST_ZERO;
            end
        end else if (take) begin
            held_ff <= 1'b1;
            special_status_word_ff <= {5'h00, trace_pend_i, push, rw,
                1'b0, rec_type, rec_mod, fault_size_i};
            if (fault_kind_i == `KIND_PRIV) begin
                fault_address_ff <= instr_addr_i;
            end else if (push && fault_size_i != `SIZE_LINE) begin
                fault_address_ff <= {fault_addr_i[31:4], failed_word_i, fault_addr_i[1:0]};
            end else begin
                fault_address_ff <= fault_addr_i;
            end
            writeback_one_status_ff <= wbs(v1, type1, fault_size_i);
            writeback_two_status_ff <= wbs(v2, wb2_type_i, wb2_size_i);
            writeback_three_status_ff <= wbs(v3, type3, size3);
            writeback_one_address_ff <= fault_addr_i;
            writeback_one_data_ff <= wb1_data_i_valid ? wb1_data_i : `RST_ZERO;
            writeback_two_data_ff <= wb2_data_i;
            writeback_three_data_ff <= wb3_data_i;
            if (saves_line) begin
                for (i = 0; i < 4; i = i + 1) begin
                    lw_ff[i] <= line_i[32*i +: 32];
                end
            end
        end else if (frame_stored_i) begin
            held_ff <= 1'b0;
        end
    end

    // ***************************************************************
    // return and checks
    // ***************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            ret_ok_o <= 1'b0;
            trace_start_o <= 1'b0;
            hit_error_o <= 1'b0;
            in_ret_ff <= 1'b0;
        end else begin
            ret_ok_o <= ret_rd_i && (ret_offset_i <= `RET_LAST);
            in_ret_ff <= wb_wr && (wb_adr_i == `OFS_CTRL) && wb_sel_i[0] &&
                wb_dat_i[`CTRL_RET];
            trace_start_o <= in_ret_ff && special_status_word_ff[`SPECIAL_TRACE];
            hit_error_o <= take && wb2_pend_i && (wb2_type_i == `TYPE_BLOCK) && !wb2_hit_i;
        end
    end

    // ***************************************************************
    // interrupts and bus
    // ***************************************************************
    wire [2:0] ev = {hit_error_o, trace_start_o, take};
    always @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= 3'h0;
            mask_ff <= 3'h0;
            ack_ff <= 1'b0;
            wb_dat_o <= `RST_ZERO;
        end else begin
            ack_ff <= wb_req;
            // set wins over clear
            if (wb_wr && wb_adr_i == `OFS_STATUS && wb_sel_i[0]) begin
                status_ff <= (status_ff & ~wb_dat_i[2:0]) | ev;
            end else begin
                status_ff <= status_ff | ev;
            end
            if (wb_wr && wb_adr_i == `OFS_MASK && wb_sel_i[0]) begin
                mask_ff <= wb_dat_i[2:0];
            end
            case (wb_adr_i)
                `OFS_STATUS: wb_dat_o <= {29'h0, status_ff};
                `OFS_MASK: wb_dat_o <= {29'h0, mask_ff};
                `OFS_SPECIAL: wb_dat_o <= {16'h0, special_status_word_ff};
                `OFS_FADDR: wb_dat_o <= fault_address_ff;
                `OFS_SLOT1_STAT: wb_dat_o <= {24'h0, writeback_one_status_ff};
                `OFS_SLOT2_STAT: wb_dat_o <= {24'h0, writeback_two_status_ff};
                `OFS_SLOT3_STAT: wb_dat_o <= {24'h0, writeback_three_status_ff};
                `OFS_SLOT1_ADDR: wb_dat_o <= writeback_one_address_ff;
                `OFS_SLOT1_DATA: wb_dat_o <= writeback_one_data_ff;
                `OFS_SLOT2_DATA: wb_dat_o <= writeback_two_data_ff;
                `OFS_SLOT3_DATA: wb_dat_o <= writeback_three_data_ff;
                `OFS_LINE0: wb_dat_o <= lw_ff[0];
                `OFS_LINE1: wb_dat_o <= lw_ff[1];
                `OFS_LINE2: wb_dat_o <= lw_ff[2];
                `OFS_LINE3: wb_dat_o <= lw_ff[3];
                `OFS_CTRL: wb_dat_o <= {30'h0, held_ff, 1'b0};
                default: wb_dat_o <= `RST_ZERO;
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign irq_o = |(status_ff & mask_ff);
endmodule // access_fault_frame_status

// ---- tb/access_fault_frame_status_asserts.sv ----
// port-level checks for the access-fault frame block
`timescale 1ns/10ps
module access_fault_frame_status_asserts (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [3:0] ret_offset_i,
    input wire ret_rd_i,
    input wire ret_ok_o,
    input wire trace_start_o,
    input wire hit_error_o
);
    // a return request is a write of bit 0 to the control word
    wire ret_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h3C && wb_dat_i[0];
    wire in_frame = ret_rd_i && ret_offset_i <= 4'hD;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ret_in_frame: assert property (in_frame |=> ret_ok_o)
        else $error("frame read refused");
    a_ret_past_frame: assert property (!in_frame |=> !ret_ok_o)
        else $error("read beyond frame accepted");
    a_trace_has_cause: assert property (trace_start_o |-> $past(ret_wr, 2) || $past(ret_wr, 3))
        else $error("trace start without return");
    a_trace_one_pulse: assert property (trace_start_o |=> !trace_start_o)
        else $error("trace start too long");
    a_hit_one_pulse: assert property (hit_error_o |=> !hit_error_o)
        else $error("hit error too long");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h3C |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule // access_fault_frame_status_asserts
bind access_fault_frame_status
    access_fault_frame_status_asserts frame_checks_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ret_offset_i, .ret_rd_i,
    .ret_ok_o, .trace_start_o, .hit_error_o);

// ---- tb/fault_source_model.sv ----
// pipeline and bus controller stand-in that raises one fault at a time
`timescale 1ns/10ps
module fault_source_model (
    input wire clk_i,
    output logic fault_i, fault_rw_i, wb1_data_i_valid, wb2_pend_i, wb2_hit_i,
    output logic wb3_pend_i, trace_pend_i, frame_stored_i,
    output logic [1:0] fault_type_i, fault_size_i, failed_word_i, wb2_type_i, wb2_size_i,
    output logic [1:0] wb3_size_i,
    output logic [2:0] fault_kind_i, fault_mod_i,
    output logic [31:0] fault_addr_i, instr_addr_i, wb1_data_i, wb2_data_i, wb3_data_i,
    output logic [127:0] line_i
);
    initial begin
        {fault_i, fault_rw_i, wb1_data_i_valid, wb2_pend_i, wb2_hit_i, wb3_pend_i} = '0;
        {trace_pend_i, frame_stored_i, fault_type_i, fault_size_i, wb2_type_i, wb2_size_i} = '0;
        {wb3_size_i, fault_kind_i, fault_mod_i, fault_addr_i, instr_addr_i} = '0;
        // failed word index kept apart from address bits so it cannot pass by luck
        failed_word_i = 2'h3;
        wb1_data_i = 32'h0101_0101;
        wb2_data_i = 32'h0202_0202;
        wb3_data_i = 32'h0303_0303;
        line_i = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
    end
    task fire(input logic [2:0] k, input logic [31:0] a, input logic [1:0] t2,
              input logic p2, hit, p3, tr);
        @(posedge clk_i);
        fault_kind_i <= k;
        fault_addr_i <= a;
        instr_addr_i <= ~a;
        fault_rw_i <= k == 3'h0;
        fault_mod_i <= (k == 3'h4) ? 3'h0 : 3'h1;
        fault_type_i <= (k == 3'h2) ? 2'h1 : 2'h0;
        wb1_data_i_valid <= k == 3'h1 || k == 3'h2;
        wb2_pend_i <= p2;
        wb2_type_i <= t2;
        wb2_hit_i <= hit;
        wb3_pend_i <= p3;
        wb3_size_i <= 2'h3;
        trace_pend_i <= tr;
        fault_i <= 1'b1;
        @(posedge clk_i);
        fault_i <= 1'b0;
    endtask
    task store_done;
        @(posedge clk_i);
        frame_stored_i <= 1'b1;
        @(posedge clk_i);
        frame_stored_i <= 1'b0;
    endtask
endmodule // fault_source_model

// ---- tb/access_fault_frame_status_bench.sv ----
// self-checking bench for the access-fault frame block
`timescale 1ns/10ps
`include "fault_frame_regs.vh"
module access_fault_frame_status_bench;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ret_rd_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 4'hF, ret_offset_i = 0;
    logic [31:0] wb_dat_i = 0, rd, wb_dat_o;
    logic wb_ack_o, ret_ok_o, trace_start_o, hit_error_o, irq_o, seen;
    logic fault_i, fault_rw_i, wb1_data_i_valid, wb2_pend_i, wb2_hit_i;
    logic wb3_pend_i, trace_pend_i, frame_stored_i;
    logic [1:0] fault_type_i, fault_size_i, failed_word_i, wb2_type_i, wb2_size_i, wb3_size_i;
    logic [2:0] fault_kind_i, fault_mod_i;
    logic [31:0] fault_addr_i, instr_addr_i, wb1_data_i, wb2_data_i, wb3_data_i;
    logic [127:0] line_i;
    int n_errors = 0, n_checks = 0, i;
    access_fault_frame_status access_fault_frame_status_i (.*);
    fault_source_model fault_source_model_i (.*);
    initial forever #50 clk_i = ~clk_i;
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n == 20) begin
            n_errors++;
            report_and_stop;
        end
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] m, exp);
        wb(1'b0, a, 32'h0);
        chk(nm, rd & m, exp);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        for (i = 0; i < 8'h44; i += 4) rchk("reset", i, '1, 32'h0);
        wb(1'b1, 8'h40, '1);
        rchk("unmapped", 8'h40, '1, 32'h0);
        wb(1'b1, `OFS_MASK, 32'h7);
        rchk("mask", `OFS_MASK, '1, 32'h7);
        $display("registers done");
        fault_source_model_i.fire(3'h1, 32'h0000_1234, 2'h0, 1, 1, 1, 0);
        rchk("special", `OFS_SPECIAL, 32'h37C, 32'h4);
        rchk("faddr", `OFS_FADDR, '1, 32'h0000_1234);
        rchk("slot1_addr", `OFS_SLOT1_ADDR, '1, 32'h0000_1234);
        rchk("slot1_stat", `OFS_SLOT1_STAT, 32'hE0, 32'h80);
        rchk("slot2_stat", `OFS_SLOT2_STAT, 32'hE0, 32'h80);
        rchk("slot3_stat", `OFS_SLOT3_STAT, 32'hE3, 32'h82);
        rchk("slot1_data", `OFS_SLOT1_DATA, '1, 32'h0101_0101);
        rchk("slot2_data", `OFS_SLOT2_DATA, '1, 32'h0202_0202);
        rchk("slot3_data", `OFS_SLOT3_DATA, '1, 32'h0303_0303);
        chk("irq", irq_o, 1);
        wb(1'b1, `OFS_STATUS, 32'h1);
        chk("irq", irq_o, 0);
        // a second fault while the frame is held must not disturb it
        fault_source_model_i.fire(3'h3, 32'h0000_9990, 2'h0, 0, 1, 0, 0);
        rchk("held", `OFS_FADDR, '1, 32'h0000_1234);
        fault_source_model_i.store_done;
        $display("write fault done");
        fault_source_model_i.fire(3'h4, 32'h0000_2000, 2'h0, 0, 1, 0, 0);
        rchk("special", `OFS_SPECIAL, 32'h37C, 32'h200);
        rchk("faddr", `OFS_FADDR, 32'hC, 32'hC);
        rchk("slot1_stat", `OFS_SLOT1_STAT, 32'h80, 32'h0);
        for (i = 0; i < 4; i++) rchk("line", 8'h2C + 4 * i, '1, (i + 1) * 32'h1111_1111);
        fault_source_model_i.store_done;
        $display("push fault done");
        fault_source_model_i.fire(3'h2, 32'h0000_3000, 2'h1, 1, 0, 1, 0);
        rchk("slot1_stat", `OFS_SLOT1_STAT, 32'hE0, 32'hA0);
        rchk("slot2_stat", `OFS_SLOT2_STAT, 32'hE0, 32'hA0);
        rchk("slot3_stat", `OFS_SLOT3_STAT, 32'h80, 32'h0);
        rchk("hit", `OFS_STATUS, 32'h4, 32'h4);
        for (i = 0; i < 4; i++) rchk("line", 8'h2C + 4 * i, '1, (i + 1) * 32'h1111_1111);
        fault_source_model_i.store_done;
        fault_source_model_i.fire(3'h3, 32'h0000_4000, 2'h0, 1, 1, 1, 0);
        rchk("faddr", `OFS_FADDR, '1, ~32'h0000_4000);
        rchk("slot1_stat", `OFS_SLOT1_STAT, 32'h80, 32'h0);
        rchk("slot2_stat", `OFS_SLOT2_STAT, 32'h80, 32'h80);
        fault_source_model_i.store_done;
        $display("move and privilege done");
        fault_source_model_i.fire(3'h0, 32'h0000_5000, 2'h0, 1, 1, 1, 1);
        rchk("special", `OFS_SPECIAL, 32'h500, 32'h500);
        rchk("slot1_stat", `OFS_SLOT1_STAT, 32'h80, 32'h0);
        rchk("slot2_stat", `OFS_SLOT2_STAT, 32'h80, 32'h0);
        rchk("slot3_stat", `OFS_SLOT3_STAT, 32'h80, 32'h80);
        wb(1'b1, `OFS_CTRL, 32'h1);
        seen = 0;
        for (i = 0; i < 6; i++) @(posedge clk_i) seen |= trace_start_o;
        chk("trace", seen, 1);
        for (i = 0; i < 16; i++) begin
            @(posedge clk_i);
            {ret_rd_i, ret_offset_i} <= {1'b1, 4'(i)};
            @(posedge clk_i);
            ret_rd_i <= 0;
            @(posedge clk_i);
            chk("ret", ret_ok_o, i <= 13);
        end
        $display("read fault and return done");
        report_and_stop;
    end
endmodule // access_fault_frame_status_bench
